// file: logic/ccr_regs.svh
// register offsets, field positions, reset values for comparator control block
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_CTRL_ADDR 8'h9A
`define CCR_MODE_ADDR 8'h9C
`define CCR_MUX_ADDR 8'h9F
`define CCR_CTRL_RST 8'h00
`define CCR_MODE_RST 8'h02
`define CCR_MUX_RST 8'h00
`define CCR_ON_BIT 7
`define CCR_LEVEL_BIT 6
`define CCR_RISE_BIT 5
`define CCR_FALL_BIT 4
`define CCR_PHYS_HI 3
`define CCR_PHYS_LO 2
`define CCR_NHYS_HI 1
`define CCR_NHYS_LO 0
`define CCR_RIE_BIT 5
`define CCR_FIE_BIT 4
`define CCR_SPD_HI 1
`define CCR_SPD_LO 0
`define CCR_NSEL_HI 5
`define CCR_NSEL_LO 4
`define CCR_PSEL_HI 1
`define CCR_PSEL_LO 0
`define CCR_SPD_RST 2'h2
`endif

// file: logic/ccr_pkg.sv
// types shared by the comparator control block
package ccr_pkg;
    typedef logic [7:0] ccr_byte_t;
    typedef logic [1:0] ccr_sel_t;
    typedef enum logic [1:0] {
        CCR_HYS_OFF = 2'h0,
        CCR_HYS_5MV = 2'h1,
        CCR_HYS_10MV = 2'h2,
        CCR_HYS_20MV = 2'h3
    } ccr_hyst_t;
endpackage

// file: logic/ccr_sync.sv
// two-stage synchroniser with edge detection for the comparator level
`include "ccr_regs.svh"
module ccr_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;
endmodule

// file: logic/ccr_top.sv
// comparator 1 control/mode registers and comparator 0 input select
`include "ccr_regs.svh"
module ccr_top (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic SFR_WR_IN,
    input wire logic SFR_RD_IN,
    input wire ccr_pkg::ccr_byte_t SFR_WDATA_IN,
    output ccr_pkg::ccr_byte_t SFR_RDATA_OUT,
    input wire logic CMP_RAW_IN,
    output logic CMP_ON_OUT,
    output ccr_pkg::ccr_sel_t POS_HYST_SEL_OUT,
    output ccr_pkg::ccr_sel_t NEG_HYST_SEL_OUT,
    output ccr_pkg::ccr_sel_t RESPONSE_SPEED_SEL_OUT,
    output ccr_pkg::ccr_sel_t POS_INPUT_SEL_OUT,
    output ccr_pkg::ccr_sel_t NEG_INPUT_SEL_OUT,
    output logic CMP_ROUTED_OUT,
    output logic RISE_IRQ_OUT,
    output logic FALL_IRQ_OUT
);
    import ccr_pkg::*;

    logic rst_m_q, rst_s_q;
    logic rst_n;
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end
    assign rst_n = rst_s_q;

    logic cmp_level, rise_ev, fall_ev;
    ccr_sync u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .async_in(CMP_RAW_IN),
        .level_out(cmp_level),
        .rise_out(rise_ev),
        .fall_out(fall_ev)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = (a == base);
    endfunction

    logic wr_ctrl, wr_mode, wr_mux;
    always_comb begin
        wr_ctrl = 1'b0;
        wr_mode = 1'b0;
        wr_mux = 1'b0;
        if (SFR_WR_IN && hit(SFR_ADDR_IN, `CCR_CTRL_ADDR)) begin
            wr_ctrl = 1'b1;
        end else if (SFR_WR_IN && hit(SFR_ADDR_IN, `CCR_MODE_ADDR)) begin
            wr_mode = 1'b1;
        end else if (SFR_WR_IN && hit(SFR_ADDR_IN, `CCR_MUX_ADDR)) begin
            wr_mux = 1'b1;
        end
    end

    logic cmp_on_q, cmp_on_d;
    logic rise_flag_q, rise_flag_d;
    logic fall_flag_q, fall_flag_d;
    ccr_sel_t pos_hyst_q, pos_hyst_d, neg_hyst_q, neg_hyst_d;
    ccr_sel_t speed_q, speed_d, psel_q, psel_d, nsel_q, nsel_d;
    logic rise_ie_q, rise_ie_d, fall_ie_q, fall_ie_d;
    ccr_byte_t rdata_q, rdata_d;
    logic routed_q, routed_d, rirq_q, rirq_d, firq_q, firq_d;

    always_comb begin
        cmp_on_d = cmp_on_q;
        rise_flag_d = rise_flag_q;
        fall_flag_d = fall_flag_q;
        pos_hyst_d = pos_hyst_q;
        neg_hyst_d = neg_hyst_q;
        speed_d = speed_q;
        rise_ie_d = rise_ie_q;
        fall_ie_d = fall_ie_q;
        psel_d = psel_q;
        nsel_d = nsel_q;
        if (wr_ctrl) begin
            cmp_on_d = SFR_WDATA_IN[`CCR_ON_BIT];
            rise_flag_d = SFR_WDATA_IN[`CCR_RISE_BIT];
            fall_flag_d = SFR_WDATA_IN[`CCR_FALL_BIT];
            pos_hyst_d = SFR_WDATA_IN[`CCR_PHYS_HI:`CCR_PHYS_LO];
            neg_hyst_d = SFR_WDATA_IN[`CCR_NHYS_HI:`CCR_NHYS_LO];
        end
        // set after the write so an edge beats a same-cycle clear
        if (rise_ev) begin
            rise_flag_d = 1'b1;
        end
        if (fall_ev) begin
            fall_flag_d = 1'b1;
        end
        if (wr_mode) begin
            speed_d = SFR_WDATA_IN[`CCR_SPD_HI:`CCR_SPD_LO];
            rise_ie_d = SFR_WDATA_IN[`CCR_RIE_BIT];
            fall_ie_d = SFR_WDATA_IN[`CCR_FIE_BIT];
        end
        if (wr_mux) begin
            nsel_d = SFR_WDATA_IN[`CCR_NSEL_HI:`CCR_NSEL_LO];
            psel_d = SFR_WDATA_IN[`CCR_PSEL_HI:`CCR_PSEL_LO];
        end
        // gated by the enable being written, so routed output changes on the same edge as CMP_ON_OUT
        routed_d = cmp_on_d & cmp_level;
        rirq_d = rise_flag_d & rise_ie_d;
        firq_d = fall_flag_d & fall_ie_d;
    end

    always_comb begin
        rdata_d = rdata_q;
        if (SFR_RD_IN) begin
            if (hit(SFR_ADDR_IN, `CCR_CTRL_ADDR)) begin
                rdata_d = {cmp_on_q, cmp_level, rise_flag_q, fall_flag_q,
                           pos_hyst_q, neg_hyst_q};
            end else if (hit(SFR_ADDR_IN, `CCR_MODE_ADDR)) begin
                rdata_d = {2'h0, rise_ie_q, fall_ie_q, 2'h0, speed_q};
            end else if (hit(SFR_ADDR_IN, `CCR_MUX_ADDR)) begin
                rdata_d = {2'h0, nsel_q, 2'h0, psel_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            cmp_on_q <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
            pos_hyst_q <= 2'h0;
            neg_hyst_q <= 2'h0;
            speed_q <= `CCR_SPD_RST;
            rise_ie_q <= 1'b0;
            fall_ie_q <= 1'b0;
            psel_q <= 2'h0;
            nsel_q <= 2'h0;
            rdata_q <= 8'h00;
            routed_q <= 1'b0;
            rirq_q <= 1'b0;
            firq_q <= 1'b0;
        end else begin
            cmp_on_q <= cmp_on_d;
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
            pos_hyst_q <= pos_hyst_d;
            neg_hyst_q <= neg_hyst_d;
            speed_q <= speed_d;
            rise_ie_q <= rise_ie_d;
            fall_ie_q <= fall_ie_d;
            psel_q <= psel_d;
            nsel_q <= nsel_d;
            rdata_q <= rdata_d;
            routed_q <= routed_d;
            rirq_q <= rirq_d;
            firq_q <= firq_d;
        end
    end

    assign SFR_RDATA_OUT = rdata_q;
    assign CMP_ON_OUT = cmp_on_q;
    assign POS_HYST_SEL_OUT = pos_hyst_q;
    assign NEG_HYST_SEL_OUT = neg_hyst_q;
    assign RESPONSE_SPEED_SEL_OUT = speed_q;
    assign POS_INPUT_SEL_OUT = psel_q;
    assign NEG_INPUT_SEL_OUT = nsel_q;
    assign CMP_ROUTED_OUT = routed_q;
    assign RISE_IRQ_OUT = rirq_q;
    assign FALL_IRQ_OUT = firq_q;

    sequence ctrl_wr_s(logic [7:0] d);
        SFR_WR_IN && SFR_ADDR_IN == `CCR_CTRL_ADDR && SFR_WDATA_IN == d;
    endsequence

    enable_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        SFR_WR_IN && SFR_ADDR_IN == `CCR_CTRL_ADDR |=> CMP_ON_OUT == $past(SFR_WDATA_IN[7]))
        else $error("enable bit did not follow write");
    level_read_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        SFR_RD_IN && SFR_ADDR_IN == `CCR_CTRL_ADDR |=> SFR_RDATA_OUT[6] == $past(cmp_level))
        else $error("level bit read wrong");
    rise_sticky_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        rise_ev |=> rise_flag_q)
        else $error("rise flag not set");
    fall_sticky_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        fall_flag_q && !fall_ev && !(SFR_WR_IN && SFR_ADDR_IN == `CCR_CTRL_ADDR)
        |=> fall_flag_q)
        else $error("fall flag lost");
    hyst_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        ctrl_wr_s(8'h0D) |=> POS_HYST_SEL_OUT == 2'h3 && NEG_HYST_SEL_OUT == 2'h1)
        else $error("hysteresis fields wrong");
    mode_read_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        SFR_RD_IN && SFR_ADDR_IN == `CCR_MODE_ADDR |=> (SFR_RDATA_OUT & 8'hCC) == 8'h00)
        else $error("unused mode bits nonzero");
    mux_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        SFR_WR_IN && SFR_ADDR_IN == `CCR_MUX_ADDR
        |=> NEG_INPUT_SEL_OUT == $past(SFR_WDATA_IN[5:4])
        && POS_INPUT_SEL_OUT == $past(SFR_WDATA_IN[1:0]))
        else $error("input select wrong");
    rise_irq_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        RISE_IRQ_OUT |-> rise_ie_q && rise_flag_q)
        else $error("rise interrupt ungated");
    routed_low_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        !cmp_on_q |-> !CMP_ROUTED_OUT)
        else $error("routed output high while off");
    edge_wins_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
        rise_ev && SFR_WR_IN && SFR_ADDR_IN == `CCR_CTRL_ADDR |=> rise_flag_q)
        else $error("edge lost to clear");
endmodule

// file: tb/ccr_cmp_model.sv
// behavioural analog comparator core driving the raw decision
module ccr_cmp_model (
    input wire logic lvl_in,
    input wire ccr_pkg::ccr_sel_t speed_in,
    output logic raw_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    // input pins taken as analog and skipped by the crossbar, so the level is clean
    initial raw_out = 1'b0;
    // output follows even while off, so the routing gate is exercised
    // slower modes answer later, always inside one system clock
    always @(lvl_in) raw_out <= #(5 * (speed_in + 1)) lvl_in;
endmodule

// file: tb/test_comparator_control_regs.sv
// self-checking bench for the comparator control registers
module test_comparator_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    logic clk, rst_n, wr, rd, lvl, raw, cmp_on, routed, rirq, firq;
    logic [7:0] addr;
    ccr_byte_t wdata, rdata, got, dm, dx, dc;
    ccr_sel_t phys, nhys, spd, psel, nsel;
    logic [7:0] unmapped [4] = '{8'h9B, 8'h9D, 8'h9E, 8'h00};
    int n_errors = 0;
    int n_tests = 0;

    ccr_top u_ccr_top (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .SFR_ADDR_IN(addr),
        .SFR_WR_IN(wr), .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata),
        .CMP_RAW_IN(raw), .CMP_ON_OUT(cmp_on), .POS_HYST_SEL_OUT(phys),
        .NEG_HYST_SEL_OUT(nhys), .RESPONSE_SPEED_SEL_OUT(spd), .POS_INPUT_SEL_OUT(psel),
        .NEG_INPUT_SEL_OUT(nsel), .CMP_ROUTED_OUT(routed), .RISE_IRQ_OUT(rirq),
        .FALL_IRQ_OUT(firq));
    ccr_cmp_model u_ccr_cmp_model (.lvl_in(lvl), .speed_in(spd), .raw_out(raw));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input ccr_byte_t g, input ccr_byte_t e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // write strobe is one cycle; outputs are looked at just after the taking edge
    task automatic wr_reg(input logic [7:0] a, input ccr_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output ccr_byte_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        lvl = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        void'($urandom(39));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(8'h9A, got); chk(got, 8'h00);
        rd_reg(8'h9C, got); chk(got, 8'h02);
        rd_reg(8'h9F, got); chk(got, 8'h00);
        chk({6'h0, spd}, 8'h02);
        for (int i = 0; i < 30; i++) begin
            dm = 8'($urandom);
            dx = 8'($urandom);
            dc = (i == 0) ? 8'hFF : 8'($urandom);
            wr_reg(8'h9C, dm); chk({6'h0, spd}, {6'h0, dm[1:0]});
            rd_reg(8'h9C, got); chk(got, dm & 8'h33);
            wr_reg(8'h9F, dx);
            chk({2'h0, nsel, 2'h0, psel}, dx & 8'h33);
            rd_reg(8'h9F, got); chk(got, dx & 8'h33);
            wr_reg(8'h9A, dc);
            chk({cmp_on, 3'h0, phys, nhys}, dc & 8'h8F);
            chk({6'h0, rirq, firq}, {6'h0, dc[5:4] & dm[5:4]});
            rd_reg(8'h9A, got); chk(got, dc & 8'hBF);
        end
        // unmapped places must neither answer nor disturb the mux register
        foreach (unmapped[k]) begin
            wr_reg(unmapped[k], 8'hFF);
            rd_reg(unmapped[k], got); chk(got, 8'h00);
        end
        rd_reg(8'h9F, got); chk(got, dx & 8'h33);
        wr_reg(8'h9C, 8'h31);
        wr_reg(8'h9A, 8'h80);
        wr_reg(8'h9A, 8'h80);
        @(posedge clk) lvl <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({4'h0, rirq, firq, routed, cmp_on}, 8'h0B);
        rd_reg(8'h9A, got); chk(got, 8'hE0);
        wr_reg(8'h9A, 8'h80); chk({7'h0, rirq}, 8'h00);
        @(posedge clk) lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd_reg(8'h9A, got); chk(got, 8'h90);
        chk({6'h0, rirq, firq}, 8'h01);
        wr_reg(8'h9C, 8'h01); chk({6'h0, rirq, firq}, 8'h00);
        // clear taken at the very edge that records the rise
        wr_reg(8'h9A, 8'h80);
        @(posedge clk) lvl <= 1'b1;
        @(posedge clk);
        wr_reg(8'h9A, 8'h80);
        rd_reg(8'h9A, got); chk(got, 8'hE0);
        // fixed hysteresis pattern, watched by the design's own check as well
        wr_reg(8'h9A, 8'h0D);
        chk({cmp_on, 3'h0, phys, nhys}, 8'h0D);
        wr_reg(8'h9A, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h0, routed, cmp_on}, 8'h00);
        wrap_up();
    end
endmodule
